/* hdl/rsbpm_pkg.sv */
// Purpose: constants shared by the strap-selected bus pin mux
// Assumes: one 250 MHz clock, APB register access
// Notes:   pad indices number the shared display/panel pad group
package rsbpm_pkg;

  // bus modes as reported in the memory configuration register
  localparam logic [1:0] MODE_LCD   = 2'h0;
  localparam logic [1:0] MODE_LOCAL = 2'h1;
  localparam logic [1:0] MODE_ISA   = 2'h2;
  localparam logic [1:0] MODE_RESET = MODE_LCD;

  // shared pad group
  localparam int NUM_PADS            = 35;
  localparam int PAD_DM_ADDR_BASE    = 0;   // display memory address bits 0..14
  localparam int PAD_LOGIC_PWR       = 15;
  localparam int PAD_DM_DATA_BASE    = 16;  // display memory data bits 0..7
  localparam int PAD_DM_OE           = 24;
  localparam int PAD_DM_CE           = 25;
  localparam int PAD_PANEL_DATA_BASE = 26;  // panel data bits 0..3
  localparam int PAD_PANEL_MOD       = 30;
  localparam int PAD_LINE            = 31;
  localparam int PAD_SHIFT           = 32;
  localparam int PAD_FRAME           = 33;
  localparam int PAD_BIAS_PWR        = 34;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_MEMORY_CONFIGURATION_ONE = 12'h066;
  localparam logic [11:0] IDX_FUNCTION_CONFIG          = 12'h067;
  localparam int          MODE_FIELD_LSB               = 5;
  localparam logic [7:0]  MEM_CFG_WRITE_MASK           = 8'h9f;
  localparam logic [7:0]  MEM_CFG_RESET                = 8'h00;
  localparam logic [5:0]  FUNC_CFG_RESET               = 6'h00;

endpackage : rsbpm_pkg

/* hdl/rsbpm_strap_latch.sv */
// Purpose: captures the two bus select straps on reset release
// Assumes: reset pins are synchronous to pclk, active low
// Notes:   power-up capture needs both resets released
`timescale 1ns/10ps
module rsbpm_strap_latch (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       primary_reset_in_n,
  input  wire logic       io_only_reset_n,
  input  wire logic       strap_select_low,
  input  wire logic       strap_select_high,
  output logic [1:0]      bus_mode,
  output logic            strap_sampling
);

  typedef struct packed {
    logic       powered;
    logic       prev_primary;
    logic       prev_both;
    logic [1:0] mode;
    logic       sampling;
  } rsbpm_latch_t;

  rsbpm_latch_t st;
  rsbpm_latch_t next_st;

  logic both_high;
  logic capture;
  logic [1:0] strap_mode;

  always_comb
  begin
    both_high = primary_reset_in_n & io_only_reset_n;
    if (strap_select_low)
      strap_mode = rsbpm_pkg::MODE_ISA;
    else if (strap_select_high)
      strap_mode = rsbpm_pkg::MODE_LOCAL;
    else
      strap_mode = rsbpm_pkg::MODE_LCD;
    if (!st.powered)
      capture = both_high & ~st.prev_both;
    else
      capture = primary_reset_in_n & ~st.prev_primary;
    next_st              = st;
    next_st.prev_primary = primary_reset_in_n;
    next_st.prev_both    = both_high;
    if (capture)
    begin
      next_st.mode    = strap_mode;
      next_st.powered = 1'b1;
    end
    next_st.sampling = ~both_high;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st.powered      <= 1'b0;
      st.prev_primary <= 1'b0;
      st.prev_both    <= 1'b0;
      st.mode         <= rsbpm_pkg::MODE_RESET;
      st.sampling     <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign bus_mode       = st.mode;
  assign strap_sampling = st.sampling;

endmodule : rsbpm_strap_latch

/* hdl/rsbpm_pin_mux.sv */
// Purpose: strap-selected routing of shared pads to LCD, local bus or ISA
// Assumes: APB slave, pins synchronous to pclk, straps held during reset
// Notes:   dma bits 0..5 = ch 0,1,3,5,6,7; irq bits 0..7 = 4,5,7,9,10,11,12,15
//
// Contract
// - straps on modem outputs captured at power-up release of both resets
// - io-only reset while primary reset high keeps the mode
// - every primary reset release resamples the straps
// - straps 00 LCD, high-only local bus, low set maximum ISA
// - latched mode readable in bits 6:5 of register index 66h
// - local mode drives upper address A22..A12 on display address pads, A23 on the logic power pad
// - local mode drives cycle strobes and byte enables on display data pads
// - local mode takes device ready and device acknowledge as inputs
// - local mode drives core ready, clock, reset on display pads
// - local cycles present low address on SA11..SA0
// - local mode unreassigned LCD pads take ISA functions
// - maximum ISA takes dma requests 0,1,3,5,6,7
// - maximum ISA drives dma acknowledges 0,1,3,5,6,7
// - maximum ISA takes interrupt requests 4,5,7,9,10,11,12,15
// - maximum ISA drives LA23..LA17 and BALE, takes channel check
// - maximum ISA drives below-1M decode, takes zero wait input
// - memory, scan, port, clock-out, card and 14 MHz via registers
// - strap pins return to serial outputs after reset release
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module rsbpm_pin_mux (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // resets and straps
  input  wire logic                    primary_reset_in_n,
  input  wire logic                    io_only_reset_n,
  input  wire logic                    dtr_src,
  input  wire logic                    rts_src,
  input  wire logic                    strap_select_high_in,
  output logic                         strap_select_high_out,
  output logic                         strap_select_high_oe,
  input  wire logic                    strap_select_low_in,
  output logic                         strap_select_low_out,
  output logic                         strap_select_low_oe,
  // shared pads
  input  wire logic [34:0]             pad_in,
  output logic [34:0]                  pad_out,
  output logic [34:0]                  pad_oe,
  // lcd controller side
  input  wire logic [34:0]             lcd_pad_out,
  input  wire logic [34:0]             lcd_pad_oe,
  output logic [34:0]                  lcd_pad_in,
  // local bus side
  input  wire logic [11:0]             lb_addr_hi,
  input  wire logic                    lb_ads_n,
  input  wire logic                    lb_data_code,
  input  wire logic                    lb_mem_io,
  input  wire logic                    lb_write_read,
  input  wire logic                    lb_bhe_n,
  input  wire logic                    lb_ble_n,
  input  wire logic                    core_ready_src,
  input  wire logic                    core_clock_src,
  input  wire logic                    core_reset_src,
  output logic                         local_device_ready,
  output logic                         local_device_ack,
  input  wire logic                    lb_cycle,
  input  wire logic [11:0]             lb_addr_lo,
  input  wire logic [11:0]             isa_sa_lo,
  output logic [11:0]                  sa_lo_out,
  // isa side
  input  wire logic [6:0]              isa_la_src,
  input  wire logic                    isa_bale_src,
  input  wire logic [5:0]              isa_dack_n_src,
  input  wire logic                    isa_below_one_meg_decode_src,
  output logic [5:0]                   isa_drq,
  output logic [7:0]                   isa_irq,
  output logic                         isa_chan_check,
  output logic                         zero_wait_input,
  // configuration
  output logic [1:0]                   bus_mode,
  output logic [7:0]                   mem_cfg_ctl,
  output logic [5:0]                   function_cfg
);

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [7:0]  mem_cfg;
    logic [5:0]  func_cfg;
    logic        hi_out;
    logic        hi_oe;
    logic        lo_out;
    logic        lo_oe;
    logic [34:0] pad_out;
    logic [34:0] pad_oe;
    logic [34:0] lcd_in;
    logic        local_device_ack_rdy;
    logic        local_device_ack_ack;
    logic [11:0] sa_lo;
    logic [5:0]  drq;
    logic [7:0]  irq;
    logic        chk;
    logic        zws;
    logic [1:0]  mode;
  } rsbpm_state_t;

  rsbpm_state_t st;
  rsbpm_state_t next_st;

  logic [1:0] latched_mode;
  logic       sampling;
  logic       is_local;
  logic       is_isa;
  logic       not_lcd;
  logic [11:0] idx;
  logic [7:0]  mem_cfg_read;

  rsbpm_strap_latch u_strap_latch (
    .pclk               (pclk),
    .presetn            (presetn),
    .primary_reset_in_n (primary_reset_in_n),
    .io_only_reset_n    (io_only_reset_n),
    .strap_select_low   (strap_select_low_in),
    .strap_select_high  (strap_select_high_in),
    .bus_mode           (latched_mode),
    .strap_sampling     (sampling)
  );

  always_comb
  begin
    is_local = (latched_mode == rsbpm_pkg::MODE_LOCAL);
    is_isa   = (latched_mode == rsbpm_pkg::MODE_ISA);
    not_lcd  = is_local | is_isa;
    idx      = {2'h0, paddr[11:2]};
    next_st  = st;
    next_st.mode = latched_mode;

    mem_cfg_read = st.mem_cfg & rsbpm_pkg::MEM_CFG_WRITE_MASK;
    mem_cfg_read[rsbpm_pkg::MODE_FIELD_LSB +: 2] = latched_mode;

    // apb: answer one cycle after setup
    if (psel && !penable)
    begin
      next_st.pready  = 1'b1;
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h0000_0000;
      if (idx == rsbpm_pkg::IDX_MEMORY_CONFIGURATION_ONE)
        next_st.prdata = {24'h00_0000, mem_cfg_read};
      else if (idx == rsbpm_pkg::IDX_FUNCTION_CONFIG)
        next_st.prdata = {26'h000_0000, st.func_cfg};
      else
        next_st.pslverr = 1'b1;
    end
    else if (psel && penable && st.pready)
    begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      if (pwrite && pstrb[0])
      begin
        if (idx == rsbpm_pkg::IDX_MEMORY_CONFIGURATION_ONE)
          next_st.mem_cfg = pwdata[7:0] & rsbpm_pkg::MEM_CFG_WRITE_MASK;
        else if (idx == rsbpm_pkg::IDX_FUNCTION_CONFIG)
          next_st.func_cfg = pwdata[5:0];
      end
    end
    else
    begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
    end

    next_st.hi_out = dtr_src;
    next_st.lo_out = rts_src;
    next_st.hi_oe  = ~sampling;
    next_st.lo_oe  = ~sampling;

    // lcd default
    next_st.pad_out = lcd_pad_out;
    next_st.pad_oe  = lcd_pad_oe & {35{~not_lcd}};
    if (!not_lcd)
      next_st.pad_oe = lcd_pad_oe;
    next_st.lcd_in = pad_in & {35{~not_lcd}};

    // isa functions on pads not taken by local bus
    if (not_lcd)
    begin
      next_st.pad_out = '0;
      next_st.pad_oe  = '0;
      next_st.pad_out[rsbpm_pkg::PAD_DM_CE]           = isa_dack_n_src[1];
      next_st.pad_oe[rsbpm_pkg::PAD_DM_CE]            = 1'b1;
      next_st.pad_out[rsbpm_pkg::PAD_PANEL_DATA_BASE] = isa_dack_n_src[3];
      next_st.pad_oe[rsbpm_pkg::PAD_PANEL_DATA_BASE]  = 1'b1;
    end

    if (is_local)
    begin
      next_st.pad_out[rsbpm_pkg::PAD_LOGIC_PWR] = lb_addr_hi[11];
      next_st.pad_oe[rsbpm_pkg::PAD_LOGIC_PWR]  = 1'b1;
      next_st.pad_out[rsbpm_pkg::PAD_DM_ADDR_BASE + 4 +: 11] = lb_addr_hi[10:0];
      next_st.pad_oe[rsbpm_pkg::PAD_DM_ADDR_BASE + 4 +: 11]  = 11'h7ff;
      next_st.pad_out[rsbpm_pkg::PAD_DM_DATA_BASE + 2 +: 6] =
        {lb_ads_n, lb_data_code, lb_mem_io, lb_write_read, lb_bhe_n, lb_ble_n};
      next_st.pad_oe[rsbpm_pkg::PAD_DM_DATA_BASE + 2 +: 6]  = 6'h3f;
      next_st.pad_out[rsbpm_pkg::PAD_DM_OE]            = core_ready_src;
      next_st.pad_oe[rsbpm_pkg::PAD_DM_OE]             = 1'b1;
      next_st.pad_out[rsbpm_pkg::PAD_DM_ADDR_BASE + 3] = core_clock_src;
      next_st.pad_oe[rsbpm_pkg::PAD_DM_ADDR_BASE + 3]  = 1'b1;
      next_st.pad_out[rsbpm_pkg::PAD_DM_ADDR_BASE + 2] = core_reset_src;
      next_st.pad_oe[rsbpm_pkg::PAD_DM_ADDR_BASE + 2]  = 1'b1;
    end
    next_st.local_device_ack_rdy = is_local & pad_in[rsbpm_pkg::PAD_DM_DATA_BASE + 1];
    next_st.local_device_ack_ack = is_local & pad_in[rsbpm_pkg::PAD_DM_DATA_BASE];

    if (is_isa)
    begin
      next_st.pad_out[rsbpm_pkg::PAD_DM_ADDR_BASE + 8 +: 7] = isa_la_src;
      next_st.pad_oe[rsbpm_pkg::PAD_DM_ADDR_BASE + 8 +: 7]  = 7'h7f;
      next_st.pad_out[rsbpm_pkg::PAD_LOGIC_PWR]             = isa_bale_src;
      next_st.pad_oe[rsbpm_pkg::PAD_LOGIC_PWR]              = 1'b1;
      next_st.pad_out[rsbpm_pkg::PAD_DM_ADDR_BASE + 7] = isa_dack_n_src[0];
      next_st.pad_out[rsbpm_pkg::PAD_DM_ADDR_BASE + 6] = isa_dack_n_src[2];
      next_st.pad_out[rsbpm_pkg::PAD_DM_ADDR_BASE + 5] = isa_dack_n_src[5];
      next_st.pad_out[rsbpm_pkg::PAD_DM_ADDR_BASE + 4] = isa_dack_n_src[4];
      next_st.pad_oe[rsbpm_pkg::PAD_DM_ADDR_BASE + 4 +: 4] = 4'hf;
      next_st.pad_out[rsbpm_pkg::PAD_DM_OE] = isa_below_one_meg_decode_src;
      next_st.pad_oe[rsbpm_pkg::PAD_DM_OE]  = 1'b1;
    end

    next_st.drq = '0;
    if (is_isa)
      next_st.drq = {pad_in[rsbpm_pkg::PAD_DM_DATA_BASE + 4], pad_in[rsbpm_pkg::PAD_DM_DATA_BASE + 1],
                     pad_in[rsbpm_pkg::PAD_PANEL_DATA_BASE + 1], pad_in[rsbpm_pkg::PAD_DM_DATA_BASE + 5],
                     pad_in[rsbpm_pkg::PAD_PANEL_DATA_BASE + 3], pad_in[rsbpm_pkg::PAD_DM_DATA_BASE + 6]};
    else if (is_local)
      next_st.drq = {2'h0, pad_in[rsbpm_pkg::PAD_PANEL_DATA_BASE + 1], 1'b0,
                     pad_in[rsbpm_pkg::PAD_PANEL_DATA_BASE + 3], 1'b0};

    next_st.irq = '0;
    if (not_lcd)
      next_st.irq = {pad_in[rsbpm_pkg::PAD_BIAS_PWR], pad_in[rsbpm_pkg::PAD_FRAME],
                     pad_in[rsbpm_pkg::PAD_DM_DATA_BASE + 2] & is_isa, pad_in[rsbpm_pkg::PAD_SHIFT],
                     pad_in[rsbpm_pkg::PAD_DM_DATA_BASE + 3] & is_isa, pad_in[rsbpm_pkg::PAD_DM_ADDR_BASE + 1],
                     pad_in[rsbpm_pkg::PAD_LINE], pad_in[rsbpm_pkg::PAD_PANEL_MOD]};

    next_st.chk = not_lcd & pad_in[rsbpm_pkg::PAD_PANEL_DATA_BASE + 2];
    next_st.zws = is_isa & pad_in[rsbpm_pkg::PAD_DM_DATA_BASE + 7];

    if (is_local && lb_cycle)
      next_st.sa_lo = lb_addr_lo;
    else
      next_st.sa_lo = isa_sa_lo;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st          <= '0;
      st.mem_cfg  <= rsbpm_pkg::MEM_CFG_RESET;
      st.func_cfg <= rsbpm_pkg::FUNC_CFG_RESET;
      st.mode     <= rsbpm_pkg::MODE_RESET;
    end
    else
      st <= next_st;
  end

  assign pready                = st.pready;
  assign prdata                = st.prdata;
  assign pslverr               = st.pslverr;
  assign strap_select_high_out = st.hi_out;
  assign strap_select_high_oe  = st.hi_oe;
  assign strap_select_low_out  = st.lo_out;
  assign strap_select_low_oe   = st.lo_oe;
  assign pad_out               = st.pad_out;
  assign pad_oe                = st.pad_oe;
  assign lcd_pad_in            = st.lcd_in;
  assign local_device_ready    = st.local_device_ack_rdy;
  assign local_device_ack      = st.local_device_ack_ack;
  assign sa_lo_out             = st.sa_lo;
  assign isa_drq               = st.drq;
  assign isa_irq               = st.irq;
  assign isa_chan_check        = st.chk;
  assign zero_wait_input       = st.zws;
  assign bus_mode              = st.mode;
  assign mem_cfg_ctl           = st.mem_cfg;
  assign function_cfg          = st.func_cfg;

endmodule : rsbpm_pin_mux

/* dv/rsbpm_checker.sv */
// Purpose: concurrent checks on the strap-selected pin mux ports
// Assumes: single pclk domain, presetn async active low
// Notes:   bound to rsbpm_pin_mux at the foot of this file
`timescale 1ns/10ps
module rsbpm_checker (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [11:0] paddr, lb_addr_hi, lb_addr_lo, isa_sa_lo, sa_lo_out,
  input wire logic [31:0] prdata,
  input wire logic        primary_reset_in_n, io_only_reset_n, strap_select_high_oe, strap_select_low_oe,
  input wire logic [34:0] pad_in, pad_out, pad_oe,
  input wire logic        lb_ads_n, lb_data_code, lb_mem_io, lb_write_read, lb_bhe_n, lb_ble_n, lb_cycle,
  input wire logic        core_ready_src, core_clock_src, core_reset_src, local_device_ready, local_device_ack,
  input wire logic [6:0]  isa_la_src,
  input wire logic        isa_bale_src, isa_below_one_meg_decode_src, zero_wait_input,
  input wire logic [5:0]  isa_dack_n_src,
  input wire logic [1:0]  bus_mode
);
  logic powered;
  // set once the power-up capture has handed the straps back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      powered <= 1'b0;
    else if (strap_select_low_oe)
      powered <= 1'b1;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_local;
    (bus_mode == rsbpm_pkg::MODE_LOCAL)[*3];
  endsequence
  sequence s_isa;
    (bus_mode == rsbpm_pkg::MODE_ISA)[*3];
  endsequence
  a_mode_readback: assert property (psel && penable && pready && !pwrite && paddr == 12'h198 |-> prdata[6:5] == bus_mode)
    else $error("mode field differs from bus mode");
  a_mode_legal: assert property (bus_mode != 2'h3)
    else $error("illegal bus mode");
  a_mode_hold: assert property ((powered && primary_reset_in_n)[*5] |-> $stable(bus_mode))
    else $error("bus mode changed without primary reset");
  a_strap_input: assert property ((!primary_reset_in_n || !io_only_reset_n)[*3] |-> !strap_select_high_oe && !strap_select_low_oe)
    else $error("strap driven during reset");
  a_strap_return: assert property ((primary_reset_in_n && io_only_reset_n)[*4] |-> strap_select_high_oe && strap_select_low_oe)
    else $error("strap not driven after reset");
  a_local_addr: assert property (s_local |-> pad_out[15:4] == $past(lb_addr_hi) && pad_oe[15:4] == 12'hfff)
    else $error("local upper address wrong");
  a_local_strobes: assert property (s_local |-> pad_out[23:18] == $past({lb_ads_n, lb_data_code, lb_mem_io,
    lb_write_read, lb_bhe_n, lb_ble_n}) && pad_oe[23:18] == 6'h3f)
    else $error("local strobes wrong");
  a_local_inputs: assert property (s_local |-> local_device_ready == $past(pad_in[17])
    && local_device_ack == $past(pad_in[16]) && pad_oe[17:16] == 2'h0)
    else $error("local ready or ack wrong");
  a_core_pins: assert property (s_local |-> {pad_out[24], pad_out[3], pad_out[2]}
    == $past({core_ready_src, core_clock_src, core_reset_src}))
    else $error("core pins wrong");
  a_low_addr: assert property (s_local |-> sa_lo_out == ($past(lb_cycle) ? $past(lb_addr_lo) : $past(isa_sa_lo)))
    else $error("low address wrong");
  a_isa_addr: assert property (s_isa |-> pad_out[15:8] == $past({isa_bale_src, isa_la_src}) && pad_oe[15:8] == 8'hff)
    else $error("isa address or latch enable wrong");
  a_isa_dack: assert property (s_isa |-> {pad_out[5], pad_out[4], pad_out[26], pad_out[6], pad_out[25], pad_out[7]}
    == $past(isa_dack_n_src))
    else $error("dma acknowledge wrong");
  a_isa_decode: assert property (s_isa |-> pad_out[24] == $past(isa_below_one_meg_decode_src) && zero_wait_input == $past(pad_in[23]))
    else $error("decode or zero wait wrong");
endmodule : rsbpm_checker

bind rsbpm_pin_mux rsbpm_checker u_rsbpm_checker (.*);

/* dv/rsbpm_board_model.sv */
// Purpose: board strap resistors and far-side bus devices on the shared pads
// Assumes: a released pad is driven by the far side with a changing pattern
// Notes:   a pad the device enables shows the device's own level
`timescale 1ns/10ps
module rsbpm_board_model (
  input  wire logic [1:0]  strap_cfg,
  input  wire logic        strap_select_high_out,
  input  wire logic        strap_select_high_oe,
  input  wire logic        strap_select_low_out,
  input  wire logic        strap_select_low_oe,
  input  wire logic [34:0] pad_out,
  input  wire logic [34:0] pad_oe,
  input  wire logic [34:0] pad_drive,
  output logic             strap_select_high_in,
  output logic             strap_select_low_in,
  output logic [34:0]      pad_in
);
  assign strap_select_high_in = strap_select_high_oe ? strap_select_high_out : strap_cfg[1];
  assign strap_select_low_in  = strap_select_low_oe ? strap_select_low_out : strap_cfg[0];
  assign pad_in               = (pad_oe & pad_out) | (~pad_oe & pad_drive);
endmodule : rsbpm_board_model

/* dv/rsbpm_pin_mux_tb.sv */
// Purpose: self-checking bench for the strap-selected pin mux
// Assumes: 250 MHz pclk, APB master, board model on the far side
// Notes:   random sources with fixed seed, every strap code visited
`timescale 1ns/10ps
module rsbpm_pin_mux_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr, lb_addr_hi, lb_addr_lo, isa_sa_lo, sa_lo_out;
  logic [31:0] pwdata, prdata, rd, wval, seed;
  logic [3:0]  pstrb;
  logic        primary_reset_in_n, io_only_reset_n, dtr_src, rts_src;
  logic        strap_select_high_in, strap_select_high_out, strap_select_high_oe;
  logic        strap_select_low_in, strap_select_low_out, strap_select_low_oe;
  logic [34:0] pad_in, pad_out, pad_oe, lcd_pad_out, lcd_pad_oe, lcd_pad_in, pad_drive;
  logic        lb_ads_n, lb_data_code, lb_mem_io, lb_write_read, lb_bhe_n, lb_ble_n, lb_cycle;
  logic        core_ready_src, core_clock_src, core_reset_src, local_device_ready, local_device_ack;
  logic [6:0]  isa_la_src;
  logic        isa_bale_src, isa_below_one_meg_decode_src, isa_chan_check, zero_wait_input;
  logic [5:0]  isa_dack_n_src, isa_drq, function_cfg;
  logic [7:0]  isa_irq, mem_cfg_ctl;
  logic [1:0]  bus_mode, strap_cfg, mode_exp;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  localparam logic [11:0] A_MEM  = rsbpm_pkg::IDX_MEMORY_CONFIGURATION_ONE << 2;
  localparam logic [11:0] A_FUNC = rsbpm_pkg::IDX_FUNCTION_CONFIG << 2;

  rsbpm_pin_mux     u_rsbpm_pin_mux (.*);
  rsbpm_board_model u_rsbpm_board_model (.*);

  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  function automatic logic [1:0] exp_mode(input logic [1:0] c);
    return c[0] ? rsbpm_pkg::MODE_ISA : (c[1] ? rsbpm_pkg::MODE_LOCAL : rsbpm_pkg::MODE_LCD);
  endfunction : exp_mode

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; a missing pready is ended only by the bench timeout
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic drive(input logic [191:0] v);
    {lcd_pad_out, lcd_pad_oe, pad_drive, lb_addr_hi, lb_addr_lo, isa_sa_lo, isa_la_src, isa_dack_n_src,
     lb_ads_n, lb_data_code, lb_mem_io, lb_write_read, lb_bhe_n, lb_ble_n, core_ready_src, core_clock_src,
     core_reset_src, lb_cycle, isa_bale_src, isa_below_one_meg_decode_src, dtr_src, rts_src} <= v[167:0];
  endtask : drive

  task automatic pin_reset(input logic [1:0] c, input logic prim);
    strap_cfg          <= c;
    primary_reset_in_n <= !prim;
    io_only_reset_n    <= 1'b0;
    repeat (4) @(posedge pclk);
    primary_reset_in_n <= 1'b1;
    io_only_reset_n    <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : pin_reset

  task automatic traffic(input int n);
    logic [5:0] drq;
    logic [7:0] irq;
    logic       lcd;
    logic [34:0] oe_exp;
    repeat (n)
    begin
      @(posedge pclk);
      drive({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
      repeat (2) @(posedge pclk);
      // pads loop back through the board; look once both edges have settled
      @(negedge pclk);
      lcd = (mode_exp == rsbpm_pkg::MODE_LCD);
      oe_exp = lcd ? lcd_pad_oe : (mode_exp == rsbpm_pkg::MODE_LOCAL ? 35'h7fc_fffc : 35'h700_fff0);
      drq = {pad_in[20], pad_in[17], pad_in[27], pad_in[21], pad_in[29], pad_in[22]};
      irq = {pad_in[34], pad_in[33], pad_in[18], pad_in[32], pad_in[19], pad_in[1], pad_in[31], pad_in[30]};
      chk(isa_drq, lcd ? 6'h00 : (mode_exp == rsbpm_pkg::MODE_LOCAL ? drq & 6'h0a : drq));
      chk(isa_irq, lcd ? 8'h00 : (mode_exp == rsbpm_pkg::MODE_LOCAL ? irq & 8'hd7 : irq));
      chk(isa_chan_check, !lcd && pad_in[28]);
      chk(lcd_pad_in, lcd ? pad_in : 35'h0);
      chk(pad_oe, oe_exp);
      chk(lcd ? pad_out : pad_out & ~oe_exp, lcd ? lcd_pad_out : 35'h0);
      chk(sa_lo_out, (mode_exp == rsbpm_pkg::MODE_LOCAL && lb_cycle) ? lb_addr_lo : isa_sa_lo);
      chk({strap_select_high_oe, strap_select_high_out, strap_select_low_oe, strap_select_low_out},
          {1'b1, dtr_src, 1'b1, rts_src});
    end
    @(posedge pclk);
  endtask : traffic

  task automatic regs;
    wval = $urandom;
    apb(1'b1, A_MEM, wval, 4'hf);
    apb(1'b1, A_MEM, ~wval, 4'h0);
    apb(1'b0, A_MEM, 32'h0, 4'h0);
    chk(rd, {24'h0, (wval[7:0] & rsbpm_pkg::MEM_CFG_WRITE_MASK) | {1'b0, mode_exp, 5'h0}});
    chk(mem_cfg_ctl, wval[7:0] & 8'h9f);
    apb(1'b1, A_FUNC, wval, 4'h1);
    apb(1'b0, A_FUNC, 32'h0, 4'h0);
    chk({er, rd, function_cfg}, {1'b0, 26'h0, wval[5:0], wval[5:0]});
    apb(1'b0, 12'h1a0, 32'h0, 4'h0);
    chk({er, rd}, {1'b1, 32'h0});
  endtask : regs

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      end_of_test;
    end
  end

  initial
  begin
    seed = $urandom(83);
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {presetn, primary_reset_in_n, io_only_reset_n} = '0;
    strap_cfg = 2'b10;
    drive('0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    pin_reset(2'b10, 1'b1);
    chk(bus_mode, exp_mode(2'b10));
    for (int c = 0; c < 4; c++)
    begin
      pin_reset(c[1:0], 1'b1);
      mode_exp = exp_mode(c[1:0]);
      chk(bus_mode, mode_exp);
      traffic(25);
      regs;
    end
    pin_reset(2'b00, 1'b0);
    chk(bus_mode, mode_exp);
    traffic(10);
    end_of_test;
  end
endmodule : rsbpm_pin_mux_tb
